/* File: rtl/sleep_seq.sv */
// low-power state sequencer with dvfs request handling
`timescale 1ns/1ps
// Operation
// - Sleep is entered from Stop-Grant when sleep request asserts, or from Deep Sleep once pll settling ends.
// - Sleep keeps context and pll, halts every internal clock.
// - Sleep neither answers snoops nor latches interrupts.
// - Reset during Sleep resets fully, skipping Stop-Grant.
// - Deep-sleep request in Sleep enters Deep Sleep, context kept.
// - Leaving Deep Sleep waits 30 us pll settling before Sleep.
// - Dropping sleep request in Sleep returns to Stop-Grant.
// - Deep Sleep ignores snoops and interrupts; bus kept static.
// - Deeper Sleep behaves exactly like Deep Sleep.
// - Raising frequency: step vid up by codes, then relock.
// - Lowering frequency: relock first, then step vid down.
// - Frequency never exceeds the rated maximum ratio.
// - Changes start only on register writes; ramp paced internally.
// - Core unavailable at most 10 us during relock.
// - Snoops held off with block-next-request during relock.
// - Stop-Grant entered 20 bus clocks after ack response phase.
module sleep_seq
    import sleep_seq_pkg::*;
#(
    parameter logic [RATIO_W-1:0] MAX_RATIO = 5'h10
)
(
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire logic               sleep_request_n,
    input  wire logic               deep_sleep_request_n,
    input  wire logic               stop_clock_request_n,
    input  wire logic               ackResponse,
    input  wire logic               snoopReq,
    input  wire logic               intReq,
    input  wire logic               msrWrite,
    input  wire logic [RATIO_W-1:0] msrRatio,
    input  wire logic [VID_W-1:0]   msrVid,
    output logic [2:0]              powerState,
    output logic                    coreClkEn,
    output logic                    pllRun,
    output logic                    snoopAck,
    output logic                    intLatched,
    output logic                    block_next_request_n,
    output logic [VID_W-1:0]        voltage_id_code,
    output logic [RATIO_W-1:0]      coreRatio,
    output logic                    dvfsBusy
);
    // pin synchronisers, first stage read only by the second
    logic [2:0] pinMeta_ff, pinSync_ff;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pinMeta_ff <= 3'h7;
            pinSync_ff <= 3'h7;
        end
        else
        begin
            pinMeta_ff <= {sleep_request_n, deep_sleep_request_n,
                           stop_clock_request_n};
            pinSync_ff <= pinMeta_ff;
        end
    end

    logic slpReq, dslpReq, stpReq;
    assign slpReq  = ~pinSync_ff[2];
    assign dslpReq = ~pinSync_ff[1];
    assign stpReq  = ~pinSync_ff[0];

    dvfs_if dv ();
    dvfs_engine u_dvfs (
        .clk_sys (clk_sys),
        .srst    (srst),
        .dv      (dv.engine)
    );

    pstate_t          st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] settleLen_ff, nxt_settleLen;
    logic             ackSeen_ff, nxt_ackSeen;
    logic             reqValid_ff, nxt_reqValid;
    logic [RATIO_W-1:0] reqRatio_ff, nxt_reqRatio;
    logic [VID_W-1:0]   reqVid_ff, nxt_reqVid;

    // clamp a software ratio to the rated maximum
    function automatic logic [RATIO_W-1:0] clampRatio(
        input logic [RATIO_W-1:0] r);
        clampRatio = (r > MAX_RATIO) ? MAX_RATIO : r;
    endfunction : clampRatio

    // power state sequencing; srst models the held reset pin, so a reset
    // taken in sleep lands in normal directly
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_cnt     = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        nxt_ackSeen = ackSeen_ff;
        // cycles spent settling, kept only for the settle checks
        nxt_settleLen = (st_ff == ST_SETTLE) ? settleLen_ff + 1'b1 : '0;
        unique case (st_ff)
            ST_NORMAL:
            begin
                if (!stpReq)
                    nxt_ackSeen = 1'b0;
                else if (ackResponse && !ackSeen_ff)
                begin
                    nxt_ackSeen = 1'b1;
                    nxt_cnt     = CNT_W'(STOPGRANT_DLY);
                end
                else if (ackSeen_ff && cnt_ff == CNT_W'(1))
                    nxt_st = ST_STOPGRANT;
            end
            ST_STOPGRANT:
                if (slpReq)
                    nxt_st = ST_SLEEP;
                else if (!stpReq)
                begin
                    nxt_st      = ST_NORMAL;
                    nxt_ackSeen = 1'b0;
                end
            ST_SLEEP:
                if (dslpReq)
                    nxt_st = ST_DEEPSLEEP;
                else if (!slpReq)
                    nxt_st = ST_STOPGRANT;
            ST_DEEPSLEEP:
                // deeper sleep is the same state at lower vcc
                if (!dslpReq)
                begin
                    nxt_st  = ST_SETTLE;
                    nxt_cnt = CNT_W'(SETTLE_CYC);
                end
            ST_SETTLE:
                if (cnt_ff == CNT_W'(1))
                    nxt_st = ST_SLEEP;
        endcase
        // deep-sleep request outside sleep falls through unused
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_ff      <= ST_NORMAL;
            cnt_ff     <= '0;
            ackSeen_ff <= 1'b0;
            settleLen_ff <= '0;
        end
        else
        begin
            st_ff      <= nxt_st;
            cnt_ff     <= nxt_cnt;
            ackSeen_ff <= nxt_ackSeen;
            settleLen_ff <= nxt_settleLen;
        end
    end

    // software writes become one-cycle requests to the engine
    always_comb
    begin
        nxt_reqValid = 1'b0;
        nxt_reqRatio = reqRatio_ff;
        nxt_reqVid   = reqVid_ff;
        if (msrWrite && !dv.busy && !reqValid_ff && st_ff == ST_NORMAL)
        begin
            nxt_reqValid = 1'b1;
            nxt_reqRatio = clampRatio(msrRatio);
            nxt_reqVid   = msrVid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reqValid_ff <= 1'b0;
            reqRatio_ff <= RATIO_RST;
            reqVid_ff   <= VID_RST;
        end
        else
        begin
            reqValid_ff <= nxt_reqValid;
            reqRatio_ff <= nxt_reqRatio;
            reqVid_ff   <= nxt_reqVid;
        end
    end

    assign dv.reqValid = reqValid_ff;
    assign dv.reqRatio = reqRatio_ff;
    assign dv.reqVid   = reqVid_ff;

    logic    awake;
    pstate_t outSt;
    assign awake = (nxt_st == ST_NORMAL) || (nxt_st == ST_STOPGRANT);
    assign outSt = nxt_st;

    // registered outputs; snoop and interrupt ignored while asleep
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            powerState           <= 3'h0;
            coreClkEn            <= 1'b1;
            pllRun               <= 1'b1;
            snoopAck             <= 1'b0;
            intLatched           <= 1'b0;
            block_next_request_n <= 1'b1;
            voltage_id_code      <= VID_RST;
            coreRatio            <= RATIO_RST;
            dvfsBusy             <= 1'b0;
        end
        else
        begin
            powerState           <= outSt;
            coreClkEn            <= (nxt_st == ST_NORMAL) && !dv.relocking;
            pllRun               <= (nxt_st != ST_DEEPSLEEP);
            snoopAck             <= snoopReq && awake;
            // a latched event is context and survives sleep; none is taken
            // while asleep, and it clears on return to normal
            intLatched           <= (nxt_st == ST_NORMAL) ? 1'b0 :
                                    (intLatched || (intReq && awake));
            block_next_request_n <= !dv.relocking;
            voltage_id_code      <= dv.curVid;
            coreRatio            <= dv.curRatio;
            dvfsBusy             <= dv.busy;
        end
    end

    sleep_entry_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_SLEEP && $past(st_ff) != ST_SLEEP) |->
        ($past(st_ff) == ST_STOPGRANT || $past(st_ff) == ST_SETTLE))
        else $error("sleep entered from wrong state");
    sleep_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_SLEEP && !slpReq && !dslpReq) |=>
        (st_ff == ST_STOPGRANT))
        else $error("sleep not left on request drop");
    deep_entry_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_SLEEP && dslpReq) |=> (st_ff == ST_DEEPSLEEP))
        else $error("deep sleep not entered");
    settle_time_a: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(st_ff == ST_SETTLE) |->
        ($past(settleLen_ff) == CNT_W'(SETTLE_CYC - 1)))
        else $error("pll settle length wrong");
    settle_done_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_SETTLE) |-> (settleLen_ff < CNT_W'(SETTLE_CYC)))
        else $error("settle overran");
    deep_ignore_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_NORMAL && dslpReq) |=> (st_ff != ST_DEEPSLEEP))
        else $error("deep sleep taken outside sleep");
    asleep_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == ST_DEEPSLEEP) |=> (!snoopAck && !coreClkEn))
        else $error("activity while asleep");
    ratio_cap_a: assert property (@(posedge clk_sys) disable iff (srst)
        coreRatio <= MAX_RATIO)
        else $error("ratio above rated maximum");
    bnr_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
        dv.relocking |=> !block_next_request_n)
        else $error("snoops not blocked in relock");
endmodule : sleep_seq

/* File: rtl/sleep_seq_pkg.sv */
// shared constants and types for the low-power state and dvfs sequencer
package sleep_seq_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          STOPGRANT_DLY    = 20;   // bus clocks after ack
    localparam int          SETTLE_US        = 30;   // pll settling time
    localparam int          SETTLE_CYC       = SETTLE_US * CLK_MHZ;
    localparam int          MAX_UNAVAIL_US   = 10;   // core unavailable max
    localparam int          RELOCK_CYC       = MAX_UNAVAIL_US * CLK_MHZ;
    localparam int          VID_STEP_CYC     = 8;    // pacing between codes
    localparam int          VID_W            = 6;
    localparam int          RATIO_W          = 5;
    localparam int          CNT_W            = 13;
    localparam logic [RATIO_W-1:0] RATIO_RST = 5'h0A;
    localparam logic [VID_W-1:0]   VID_RST   = 6'h20;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_STOPGRANT,
        ST_SLEEP,
        ST_DEEPSLEEP,
        ST_SETTLE
    } pstate_t;
endpackage : sleep_seq_pkg

/* File: rtl/dvfs_if.sv */
// request and status bundle between the sequencer and its dvfs engine
`timescale 1ns/1ps
interface dvfs_if;
    import sleep_seq_pkg::*;
    logic               reqValid;
    logic [RATIO_W-1:0] reqRatio;
    logic [VID_W-1:0]   reqVid;
    logic               busy;
    logic               relocking;
    logic [RATIO_W-1:0] curRatio;
    logic [VID_W-1:0]   curVid;

    modport master (output reqValid, reqRatio, reqVid,
                    input busy, relocking, curRatio, curVid);
    modport engine (input reqValid, reqRatio, reqVid,
                    output busy, relocking, curRatio, curVid);
endinterface : dvfs_if

/* File: rtl/dvfs_engine.sv */
// voltage and frequency stepping engine
`timescale 1ns/1ps
module dvfs_engine
    import sleep_seq_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic srst,
    dvfs_if.engine    dv
);
    typedef enum logic [1:0] {DV_IDLE, DV_UP, DV_LOCK, DV_DOWN} dvst_t;

    dvst_t              st_ff, nxt_st;
    logic [RATIO_W-1:0] ratio_ff, nxt_ratio, tRatio_ff, nxt_tRatio;
    logic [VID_W-1:0]   vid_ff, nxt_vid, tVid_ff, nxt_tVid;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic [CNT_W-1:0]   lockLen_ff, nxt_lockLen;

    // next-state: raise voltage before relock, lower it after
    always_comb
    begin
        nxt_st     = st_ff;
        nxt_ratio  = ratio_ff;
        nxt_tRatio = tRatio_ff;
        nxt_vid    = vid_ff;
        nxt_tVid   = tVid_ff;
        nxt_cnt    = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        // cycles spent in relock, kept only for the bound check
        nxt_lockLen = (st_ff == DV_LOCK) ? lockLen_ff + 1'b1 : '0;
        unique case (st_ff)
            DV_IDLE:
                if (dv.reqValid)
                begin
                    nxt_tRatio = dv.reqRatio;
                    nxt_tVid   = dv.reqVid;
                    if (dv.reqRatio > ratio_ff)
                        nxt_st = DV_UP;
                    else
                    begin
                        nxt_st  = DV_LOCK;
                        // the count runs through zero, so load one less
                        nxt_cnt = CNT_W'(RELOCK_CYC - 1);
                    end
                end
            DV_UP:
                if (cnt_ff == '0)
                begin
                    if (vid_ff < tVid_ff)
                    begin
                        nxt_vid = vid_ff + 1'b1; // one code per step
                        nxt_cnt = CNT_W'(VID_STEP_CYC);
                    end
                    else
                    begin
                        nxt_st  = DV_LOCK;
                        nxt_cnt = CNT_W'(RELOCK_CYC - 1);
                    end
                end
            DV_LOCK:
                if (cnt_ff == '0)
                begin
                    nxt_ratio = tRatio_ff;
                    nxt_st    = DV_DOWN;
                end
            DV_DOWN:
                if (cnt_ff == '0)
                begin
                    if (vid_ff > tVid_ff)
                    begin
                        nxt_vid = vid_ff - 1'b1;
                        nxt_cnt = CNT_W'(VID_STEP_CYC);
                    end
                    else
                        nxt_st = DV_IDLE;
                end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_ff     <= DV_IDLE;
            ratio_ff  <= RATIO_RST;
            tRatio_ff <= RATIO_RST;
            vid_ff    <= VID_RST;
            tVid_ff   <= VID_RST;
            cnt_ff    <= '0;
            lockLen_ff <= '0;
        end
        else
        begin
            st_ff     <= nxt_st;
            ratio_ff  <= nxt_ratio;
            tRatio_ff <= nxt_tRatio;
            vid_ff    <= nxt_vid;
            tVid_ff   <= nxt_tVid;
            cnt_ff    <= nxt_cnt;
            lockLen_ff <= nxt_lockLen;
        end
    end

    assign dv.busy      = (st_ff != DV_IDLE);
    assign dv.relocking = (st_ff == DV_LOCK);
    assign dv.curRatio  = ratio_ff;
    assign dv.curVid    = vid_ff;

    // relock window bounded by the unavailability limit
    relock_bound_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == DV_LOCK) |-> (lockLen_ff < CNT_W'(RELOCK_CYC)))
        else $error("relock lasted too long");
    vid_step_a: assert property (@(posedge clk_sys) disable iff (srst)
        (vid_ff != $past(vid_ff)) |->
        (vid_ff == $past(vid_ff) + 1'b1 || vid_ff == $past(vid_ff) - 1'b1))
        else $error("vid moved more than one code");
    up_before_lock_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == DV_UP) |-> (ratio_ff == $past(ratio_ff)))
        else $error("ratio changed during vid ramp up");
    down_after_lock_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_ff == DV_DOWN && vid_ff < $past(vid_ff)) |->
        (ratio_ff == tRatio_ff))
        else $error("vid lowered before relock");
endmodule : dvfs_engine

/* File: bench/chipset_model.sv */
// chipset model driving the power-state request pins of the sequencer
`timescale 1ns/1ps
module chipset_model
(
    input  wire logic       clk_sys,
    input  wire logic [2:0] powerState,
    output logic            sleep_request_n,
    output logic            deep_sleep_request_n,
    output logic            stop_clock_request_n,
    output logic            ackResponse,
    output logic            snoopReq,
    output logic            intReq
);
    // idle pins; snoops and interrupts only pulsed while the core is awake
    initial
    begin
        sleep_request_n      = 1'h1;
        deep_sleep_request_n = 1'h1;
        stop_clock_request_n = 1'h1;
        ackResponse          = 1'h0;
        snoopReq             = 1'h0;
        intReq               = 1'h0;
    end

    // every pin change lands just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic setStop(input logic on);
        stop_clock_request_n = ~on;
        tick(1);
    endtask : setStop

    // response phase of the stop-grant acknowledge cycle
    task automatic ackPulse();
        ackResponse = 1'h1;
        tick(1);
        ackResponse = 1'h0;
    endtask : ackPulse

    // sleep only asked for in stop-grant, held well over one clock
    task automatic setSleep(input logic on);
        if (on && powerState !== 3'h1)
            return;
        sleep_request_n = ~on;
        tick(2);
    endtask : setSleep

    task automatic setDeep(input logic on);
        deep_sleep_request_n = ~on;
        tick(1);
    endtask : setDeep

    // one-cycle snoop; never sent in or around sleep
    task automatic snoopPulse();
        snoopReq = 1'h1;
        tick(1);
        snoopReq = 1'h0;
    endtask : snoopPulse

    // one-cycle interrupt; bus stays static while asleep
    task automatic intPulse();
        intReq = 1'h1;
        tick(1);
        intReq = 1'h0;
    endtask : intPulse

    // called right after reset is raised while asleep
    task automatic dropAll();
        sleep_request_n      = 1'h1;
        stop_clock_request_n = 1'h1;
    endtask : dropAll
endmodule : chipset_model

/* File: bench/cpu_sleep_state_and_dvfs_seq_tb.sv */
// self-checking testbench for the low-power sequencer and dvfs stepping
`timescale 1ns/1ps
module cpu_sleep_state_and_dvfs_seq_tb
    import sleep_seq_pkg::*;
;
    localparam logic [RATIO_W-1:0] MAXR = 5'h10;
    logic               clk_sys, srst, clkStop, msrWrite;
    logic [RATIO_W-1:0] msrRatio, coreRatio;
    logic [VID_W-1:0]   msrVid, voltage_id_code;
    logic [2:0]         powerState;
    logic               sleepN, deepN, stopN, ack, snoop, intr;
    logic               coreClkEn, pllRun, snoopAck, intLatched;
    logic               bnrN, dvfsBusy;
    int                 n_errors, cmp_count;

    sleep_seq #(.MAX_RATIO(MAXR)) i_dut (
        .clk_sys(clk_sys), .srst(srst), .sleep_request_n(sleepN),
        .deep_sleep_request_n(deepN), .stop_clock_request_n(stopN),
        .ackResponse(ack), .snoopReq(snoop), .intReq(intr),
        .msrWrite(msrWrite), .msrRatio(msrRatio), .msrVid(msrVid),
        .powerState(powerState), .coreClkEn(coreClkEn), .pllRun(pllRun),
        .snoopAck(snoopAck), .intLatched(intLatched),
        .block_next_request_n(bnrN), .voltage_id_code(voltage_id_code),
        .coreRatio(coreRatio), .dvfsBusy(dvfsBusy));

    chipset_model i_chip (
        .clk_sys(clk_sys), .powerState(powerState),
        .sleep_request_n(sleepN), .deep_sleep_request_n(deepN),
        .stop_clock_request_n(stopN), .ackResponse(ack),
        .snoopReq(snoop), .intReq(intr));

    // the far side may freeze the bus clock, so the generator can pause
    initial
    begin
        clk_sys = 1'h0;
        forever
        begin
            #5;
            if (!clkStop)
                clk_sys = ~clk_sys;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic conclude();
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // bounded wait; a state that never shows up ends the run
    task automatic waitState(input pstate_t s, input int n);
        for (int i = 0; i < n && powerState !== s; i++)
            tick(1);
        if (powerState !== s)
        begin
            chk(16'(powerState), 16'(s));
            conclude();
        end
    endtask : waitState

    task automatic scnReset();
        chk(16'(powerState), 16'(ST_NORMAL));
        chk(16'({coreClkEn, pllRun, bnrN, snoopAck, dvfsBusy, intLatched}),
            16'h0038);
        chk(16'(voltage_id_code), 16'(VID_RST));
        chk(16'(coreRatio), 16'(RATIO_RST));
    endtask : scnReset

    // deep-sleep request while running changes nothing
    task automatic scnDeepOutside();
        i_chip.setDeep(1'h1);
        tick(8);
        chk(16'(powerState), 16'(ST_NORMAL));
        i_chip.setDeep(1'h0);
        tick(4);
    endtask : scnDeepOutside

    // snoop echoed for one cycle while awake; interrupt kept in stop-grant
    task automatic scnSnoopInt(input logic inGrant);
        i_chip.snoopPulse();
        chk(16'(snoopAck), 16'h0001);
        tick(1);
        chk(16'(snoopAck), 16'h0000);
        i_chip.intPulse();
        chk(16'(intLatched), 16'(inGrant));
        tick(1);
    endtask : scnSnoopInt

    // one software target; ordering of vid steps and relock watched
    task automatic runDvfs(input logic [RATIO_W-1:0] r,
                           input logic [VID_W-1:0] v,
                           input logic [RATIO_W-1:0] expR, input logic up);
        logic [RATIO_W-1:0] pR;
        logic [VID_W-1:0]   pV, v0;
        int                 lowCnt, i;
        logic               seen;
        pR = coreRatio;
        pV = voltage_id_code;
        v0 = pV;
        lowCnt = 0;
        seen = 1'h0;
        msrRatio = r;
        msrVid = v;
        msrWrite = 1'h1;
        tick(1);
        msrWrite = 1'h0;
        for (i = 0; i < 20000 && !(seen && dvfsBusy === 1'h0); i++)
        begin
            tick(1);
            if (i == 6)
                msrWrite = 1'h1; // must be dropped while busy
            if (i == 7)
                msrWrite = 1'h0;
            if (dvfsBusy === 1'h1)
                seen = 1'h1;
            if (voltage_id_code !== pV)
            begin
                chk(16'(voltage_id_code),
                    16'(up ? pV + 6'h01 : pV - 6'h01));
                chk(16'(coreRatio), 16'(up ? pR : expR));
            end
            if (coreRatio !== pR)
                chk(16'(voltage_id_code), 16'(up ? v : v0));
            lowCnt = (bnrN === 1'h0) ? lowCnt + 1 : 0;
            if (bnrN === 1'h0 && lowCnt == 1)
                chk(16'(coreClkEn), 16'h0000);
            if (lowCnt > RELOCK_CYC)
                chk(16'(lowCnt), 16'(RELOCK_CYC));
            pR = coreRatio;
            pV = voltage_id_code;
        end
        if (!seen || dvfsBusy !== 1'h0)
        begin
            chk(16'(dvfsBusy), 16'h0000);
            conclude();
        end
        chk(16'(coreRatio), 16'(expR));
        chk(16'(voltage_id_code), 16'(v));
        chk(16'({bnrN, coreClkEn}), 16'h0003);
        msrRatio = 5'h01;
        msrVid = 6'h01;
    endtask : runDvfs

    // stop-grant lands twenty clocks after the acknowledge response
    task automatic scnStopGrant();
        i_chip.setStop(1'h1);
        tick(3);
        i_chip.ackPulse();
        tick(19);
        chk(16'(powerState), 16'(ST_NORMAL));
        tick(1);
        chk(16'(powerState), 16'(ST_STOPGRANT));
    endtask : scnStopGrant

    task automatic scnSleepDeep();
        i_chip.setSleep(1'h1);
        waitState(ST_SLEEP, 8);
        chk(16'({coreClkEn, pllRun, intLatched}), 16'h0003);
        i_chip.setDeep(1'h1);
        waitState(ST_DEEPSLEEP, 8);
        chk(16'({coreClkEn, pllRun, intLatched}), 16'h0001);
        clkStop = 1'h1;
        #200;
        clkStop = 1'h0;
        tick(2);
        i_chip.setDeep(1'h0);
        tick(SETTLE_CYC - 8);
        chk(16'(powerState), 16'(ST_SETTLE));
        waitState(ST_SLEEP, 16);
        chk(16'({coreClkEn, pllRun, intLatched}), 16'h0003);
    endtask : scnSleepDeep

    task automatic scnSleepExit();
        i_chip.setSleep(1'h0);
        waitState(ST_STOPGRANT, 8);
        tick(10);
        i_chip.setStop(1'h0);
        waitState(ST_NORMAL, 8);
        chk(16'({coreClkEn, intLatched}), 16'h0002);
    endtask : scnSleepExit

    // reset inside sleep goes straight to normal, never via stop-grant
    task automatic scnResetInSleep();
        scnStopGrant();
        i_chip.setSleep(1'h1);
        waitState(ST_SLEEP, 8);
        srst = 1'h1;
        i_chip.dropAll();
        tick(1);
        chk(16'(powerState), 16'(ST_NORMAL));
        tick(9);
        srst = 1'h0;
        for (int i = 0; i < 30; i++)
        begin
            tick(1);
            if (powerState !== ST_NORMAL)
                chk(16'(powerState), 16'(ST_NORMAL));
        end
        scnReset();
    endtask : scnResetInSleep

    initial
    begin
        n_errors = 0;
        cmp_count = 0;
        clkStop = 1'h0;
        srst = 1'h1;
        msrWrite = 1'h0;
        msrRatio = 5'h01;
        msrVid = 6'h01;
        tick(10);
        srst = 1'h0;
        tick(3);
        scnReset();
        scnDeepOutside();
        scnSnoopInt(1'h0);
        runDvfs(5'h0C, 6'h23, 5'h0C, 1'h1);
        runDvfs(5'h08, 6'h21, 5'h08, 1'h0);
        runDvfs(5'h1F, 6'h24, MAXR, 1'h1);
        scnStopGrant();
        scnSnoopInt(1'h1);
        scnSleepDeep();
        scnSleepExit();
        scnResetInSleep();
        conclude();
    end
endmodule : cpu_sleep_state_and_dvfs_seq_tb
